// ---- common/i2csad_pkg.sv ----
// Package for the two-wire own-address and data/command block.
// Assumes APB byte addresses and a 40 MHz pclk.
`default_nettype none
package i2csad_pkg;
    localparam logic [31:0] ADDR_OWN     = 32'h5000_1308;
    localparam logic [31:0] ADDR_DATA    = 32'h5000_1310;
    localparam logic [31:0] ADDR_CTRL    = 32'h5000_1380;
    localparam logic [31:0] ADDR_RAWSTAT = 32'h5000_1384;
    localparam logic [31:0] ADDR_MASK    = 32'h5000_1388;
    localparam logic [31:0] ADDR_QSTAT   = 32'h5000_138C;

    localparam logic [9:0]  OWN_RESET    = 10'h055;
    localparam int          OWN_W        = 10;
    localparam int          DATA_W       = 8;
    localparam int          CMD_W        = 9;
    localparam int          CMD_DIR_BIT  = 8;

    // Control register fields
    localparam int          CTL_ENABLE   = 0;
    localparam int          CTL_MASTER   = 1;
    localparam int          CTL_SLV10    = 3;
    localparam int          CTL_GC_START = 10;
    localparam int          CTL_SPECIAL  = 11;
    localparam int          CTL_W        = 12;
    localparam logic [11:0] CTL_RESET    = 12'h002;

    // Raw status / mask fields
    localparam int          ST_RX_DONE   = 2;
    localparam int          ST_RD_REQ    = 5;
    localparam int          ST_TX_ABORT  = 6;
    localparam int          ST_STOP      = 9;
    localparam int          ST_W         = 10;
    localparam logic [9:0]  ST_USED      = 10'h264;

    localparam logic [4:0]  TEN_BIT_HDR  = 5'h1E;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        I2CSAD_IDLE, I2CSAD_ADDR, I2CSAD_ADDR2, I2CSAD_ACK, I2CSAD_RX,
        I2CSAD_TX_WAIT, I2CSAD_TX, I2CSAD_TX_ACK
    } i2csad_state_t;
endpackage
`default_nettype wire

// ---- hdl/i2csad_sync.sv ----
// Two-flop synchroniser for pins that arrive from outside pclk.
// Assumes the inputs are slow compared with pclk.
`timescale 1ns/1ps
`default_nettype none
module i2csad_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '1;
            q        <= '1;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // i2csad_sync
`default_nettype wire

// ---- hdl/i2csad_core.sv ----
// Own slave address holder, data/command port and slave bus engine.
// Assumes APB master on pclk; master sequencing is done downstream.
// Notes on behaviour
// - Ten-bit own address used as slave.
// - Seven-bit mode compares own address bits 6:0.
// - Own address writable only while disabled.
// - Command bit 8: one reads, zero writes.
// - Slave direction comes from remote master.
// - Queue stores each command with direction.
// - Slave receiver needs no command writes.
// - Slave transmitter sends software-written direction-zero bytes; tx_load sends the queue head's low byte whatever its bit 8.
// - Read after general call raises abort.
// - Read command after read request aborts.
// - Simultaneous slave read: drop, abort, serve.
// - Low eight command bits are data.
// - Read commands ignore their data bits.
// - Register read returns received byte.
// - General call mode lasts while special set and CTL_GC_START clear.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module i2csad_core #(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Two-wire bus pins
    input  wire logic                        scl_in,
    output logic                             scl_out,
    output logic                             scl_oe,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    // Command stream to the master sequencer
    output logic                             mst_cmd_valid,
    output logic                             mst_cmd_read,
    output logic      [i2csad_pkg::DATA_W-1:0] mst_cmd_data,
    input  wire logic                        mst_cmd_ready,
    // Interrupt
    output logic                             irq
);
    import i2csad_pkg::*;
    localparam int TXA = $clog2(TX_DEPTH);
    localparam int RXA = $clog2(RX_DEPTH);
    if (TX_DEPTH < 2 || (1 << TXA) != TX_DEPTH ||
        RX_DEPTH < 2 || (1 << RXA) != RX_DEPTH) begin : g_depth_check
        $error("Queue depths must be powers of two, at least 2");
    end
    function automatic logic [TXA:0] tx_inc(input logic [TXA:0] p);
        return p + {{TXA{1'b0}}, 1'b1};
    endfunction
    function automatic logic [RXA:0] rx_inc(input logic [RXA:0] p);
        return p + {{RXA{1'b0}}, 1'b1};
    endfunction
    logic [OWN_W-1:0]   own_address_field_reg;
    logic [CTL_W-1:0]   ctrl_reg;
    logic [ST_W-1:0]    raw_status_reg;
    logic [ST_W-1:0]    mask_reg;
    logic [CMD_W-1:0]   txq_mem [TX_DEPTH];
    logic [DATA_W-1:0]  rxq_mem [RX_DEPTH];
    logic [TXA:0]       tx_wr_reg, tx_rd_reg;
    logic [RXA:0]       rx_wr_reg, rx_rd_reg;
    i2csad_state_t      state_reg, ack_next_reg;
    logic [3:0]         bit_cnt_reg;
    logic [7:0]         shift_reg;
    logic               ten_hit_reg;
    logic               tx_acked_reg;
    logic               rd_req_pend_reg;
    logic [1:0]         pin_s;
    logic               scl_d_reg, sda_d_reg;
    wire logic interface_enable_control = ctrl_reg[CTL_ENABLE];
    wire logic gc_mode = ctrl_reg[CTL_SPECIAL] &&
                         !ctrl_reg[CTL_GC_START];
    wire logic tx_empty = (tx_wr_reg == tx_rd_reg);
    wire logic tx_full  = (tx_wr_reg[TXA] != tx_rd_reg[TXA]) &&
                          (tx_wr_reg[TXA-1:0] == tx_rd_reg[TXA-1:0]);
    wire logic rx_empty = (rx_wr_reg == rx_rd_reg);
    wire logic rx_full  = (rx_wr_reg[RXA] != rx_rd_reg[RXA]) &&
                          (rx_wr_reg[RXA-1:0] == rx_rd_reg[RXA-1:0]);
    wire logic [CMD_W-1:0] tx_head = txq_mem[tx_rd_reg[TXA-1:0]];
    // APB decode
    wire logic apb_go  = psel && penable && !pready;
    wire logic hit_own = (paddr == ADDR_OWN);
    wire logic hit_dat = (paddr == ADDR_DATA);
    wire logic hit_ctl = (paddr == ADDR_CTRL);
    wire logic hit_st  = (paddr == ADDR_RAWSTAT);
    wire logic hit_msk = (paddr == ADDR_MASK);
    wire logic hit_qs  = (paddr == ADDR_QSTAT);
    wire logic hit_any = hit_own || hit_dat || hit_ctl || hit_st ||
                         hit_msk || hit_qs;
    wire logic wr_go   = apb_go && pwrite;
    wire logic rd_go   = apb_go && !pwrite;
    wire logic cmd_wr  = wr_go && hit_dat;
    // Pin edges after synchronisation
    i2csad_sync #(
        .W (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({scl_in, sda_in}),
        .q       (pin_s)
    );
    wire logic scl_s    = pin_s[1];
    wire logic sda_s    = pin_s[0];
    wire logic scl_rise = scl_s && !scl_d_reg;
    wire logic scl_fall = !scl_s && scl_d_reg;
    wire logic start_c  = scl_s && scl_d_reg && !sda_s && sda_d_reg;
    wire logic stop_c   = scl_s && scl_d_reg && sda_s && !sda_d_reg;
    wire logic hdr_ok    = (shift_reg[7:3] == TEN_BIT_HDR) &&
                           (shift_reg[2:1] == own_address_field_reg[9:8]);
    wire logic match7    = (shift_reg[7:1] ==
                            own_address_field_reg[6:0]);
    wire logic slv10     = ctrl_reg[CTL_SLV10];
    wire logic byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
    wire logic addr_rd   = byte_done && (state_reg == I2CSAD_ADDR) &&
                           shift_reg[0] &&
                           (slv10 ? (hdr_ok && ten_hit_reg) : match7);
    wire logic addr_wr1  = byte_done && (state_reg == I2CSAD_ADDR) &&
                           !shift_reg[0] && (slv10 ? hdr_ok : match7);
    wire logic addr2_ok  = byte_done && (state_reg == I2CSAD_ADDR2) &&
                           (shift_reg == own_address_field_reg[7:0]);
    wire logic rx_push   = byte_done && (state_reg == I2CSAD_RX) &&
                           !rx_full;
    wire logic tx_load   = (state_reg == I2CSAD_TX_WAIT) && !tx_empty;
    wire logic is_read   = pwdata[CMD_DIR_BIT];
    wire logic abort_gc  = cmd_wr && is_read && gc_mode;
    wire logic abort_rq  = cmd_wr && is_read &&
                           (rd_req_pend_reg || addr_rd);
    wire logic tx_abort  = abort_gc || abort_rq;
    wire logic tx_push   = cmd_wr && !tx_abort && !tx_full;
    // Master hand-off stage, idle while slave transmit owns the queue
    wire logic slv_tx    = (state_reg == I2CSAD_TX_WAIT) ||
                           (state_reg == I2CSAD_TX) ||
                           (state_reg == I2CSAD_TX_ACK) || rd_req_pend_reg;
    wire logic mst_load  = ctrl_reg[CTL_MASTER] && interface_enable_control &&
                           !slv_tx && !tx_empty &&
                           (!mst_cmd_valid || mst_cmd_ready);
    wire logic tx_pop    = tx_load || mst_load;
    wire logic rx_pop    = rd_go && hit_dat && !rx_empty;
    // APB answer: one wait state, then pready for one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_go;
            pslverr <= apb_go && !hit_any;
            prdata  <= 32'h0000_0000;
            if (rd_go) begin
                if (hit_own) begin
                    prdata[OWN_W-1:0] <= own_address_field_reg;
                end else if (hit_dat) begin
                    prdata[DATA_W-1:0] <= rx_empty ? 8'h00 :
                        rxq_mem[rx_rd_reg[RXA-1:0]];
                end else if (hit_ctl) begin
                    prdata[CTL_W-1:0] <= ctrl_reg;
                end else if (hit_st) begin
                    prdata[ST_W-1:0] <= raw_status_reg;
                end else if (hit_msk) begin
                    prdata[ST_W-1:0] <= mask_reg;
                end else if (hit_qs) begin
                    prdata[TXA:0]       <= tx_wr_reg - tx_rd_reg;
                    prdata[16+RXA:16]   <= rx_wr_reg - rx_rd_reg;
                end
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_address_field_reg <= OWN_RESET;
            ctrl_reg              <= CTL_RESET;
            mask_reg              <= '0;
        end else if (wr_go) begin
            if (hit_own && !interface_enable_control) begin
                own_address_field_reg <= pwdata[OWN_W-1:0];
            end else if (hit_ctl) begin
                ctrl_reg <= pwdata[CTL_W-1:0];
            end else if (hit_msk) begin
                mask_reg <= pwdata[ST_W-1:0] & ST_USED;
            end
        end
    end
    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_status_reg <= '0;
            irq            <= 1'b0;
        end else begin
            logic [ST_W-1:0] set_v;
            set_v              = '0;
            set_v[ST_RX_DONE]  = rx_push;
            set_v[ST_RD_REQ]   = addr_rd;
            set_v[ST_TX_ABORT] = tx_abort;
            set_v[ST_STOP]     = stop_c && (state_reg != I2CSAD_IDLE);
            raw_status_reg <= (raw_status_reg &
                               ~((wr_go && hit_st) ? pwdata[ST_W-1:0] : '0))
                              | set_v;
            irq <= |(raw_status_reg & mask_reg);
        end
    end
    // Transmit queue with direction bit kept per entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wr_reg <= '0;
            tx_rd_reg <= '0;
        end else begin
            if (tx_push) begin
                txq_mem[tx_wr_reg[TXA-1:0]] <= pwdata[CMD_W-1:0];
                tx_wr_reg <= tx_inc(tx_wr_reg);
            end
            if (tx_pop) begin
                tx_rd_reg <= tx_inc(tx_rd_reg);
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wr_reg <= '0;
            rx_rd_reg <= '0;
        end else begin
            if (rx_push) begin
                rxq_mem[rx_wr_reg[RXA-1:0]] <= shift_reg;
                rx_wr_reg <= rx_inc(rx_wr_reg);
            end
            if (rx_pop) begin
                rx_rd_reg <= rx_inc(rx_rd_reg);
            end
        end
    end
    // Master hand-off register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst_cmd_valid <= 1'b0;
            mst_cmd_read  <= 1'b0;
            mst_cmd_data  <= '0;
        end else if (mst_load) begin
            mst_cmd_valid <= 1'b1;
            mst_cmd_read  <= tx_head[CMD_DIR_BIT];
            mst_cmd_data  <= tx_head[CMD_DIR_BIT] ? '0 :
                             tx_head[DATA_W-1:0];
        end else if (mst_cmd_ready) begin
            mst_cmd_valid <= 1'b0;
        end
    end
    // Slave bus engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= I2CSAD_IDLE;
            ack_next_reg    <= I2CSAD_IDLE;
            bit_cnt_reg     <= '0;
            shift_reg       <= '0;
            ten_hit_reg     <= 1'b0;
            tx_acked_reg    <= 1'b0;
            rd_req_pend_reg <= 1'b0;
            scl_d_reg       <= 1'b1;
            sda_d_reg       <= 1'b1;
            scl_out         <= 1'b0;
            sda_out         <= 1'b0;
            scl_oe          <= 1'b0;
            sda_oe          <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            if (!interface_enable_control || stop_c) begin
                state_reg       <= I2CSAD_IDLE;
                ten_hit_reg     <= 1'b0;
                rd_req_pend_reg <= 1'b0;
                scl_oe          <= 1'b0;
                sda_oe          <= 1'b0;
            end else if (start_c) begin
                state_reg   <= I2CSAD_ADDR;
                bit_cnt_reg <= '0;
                sda_oe      <= 1'b0;
                scl_oe      <= 1'b0;
            end else begin
                case (state_reg)
                    I2CSAD_ADDR, I2CSAD_ADDR2, I2CSAD_RX: begin
                        if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
                            shift_reg   <= {shift_reg[6:0], sda_s};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt_reg <= '0;
                            if (addr_rd) begin
                                rd_req_pend_reg <= 1'b1;
                                sda_oe       <= 1'b1;
                                state_reg    <= I2CSAD_ACK;
                                ack_next_reg <= I2CSAD_TX_WAIT;
                            end else if (addr_wr1) begin
                                sda_oe       <= 1'b1;
                                state_reg    <= I2CSAD_ACK;
                                ack_next_reg <= slv10 ? I2CSAD_ADDR2 :
                                                        I2CSAD_RX;
                            end else if (addr2_ok) begin
                                ten_hit_reg  <= 1'b1;
                                sda_oe       <= 1'b1;
                                state_reg    <= I2CSAD_ACK;
                                ack_next_reg <= I2CSAD_RX;
                            end else if (rx_push) begin
                                sda_oe       <= 1'b1;
                                state_reg    <= I2CSAD_ACK;
                                ack_next_reg <= I2CSAD_RX;
                            end else begin
                                state_reg    <= I2CSAD_IDLE;
                            end
                        end
                    end
                    I2CSAD_ACK: begin
                        if (scl_fall) begin
                            sda_oe    <= 1'b0;
                            state_reg <= ack_next_reg;
                            if (ack_next_reg == I2CSAD_TX_WAIT) begin
                                scl_oe <= 1'b1;
                            end
                        end
                    end
                    I2CSAD_TX_WAIT: begin
                        scl_oe <= 1'b1;
                        if (tx_load) begin
                            shift_reg       <= tx_head[DATA_W-1:0];
                            sda_oe          <= !tx_head[DATA_W-1];
                            bit_cnt_reg     <= '0;
                            rd_req_pend_reg <= 1'b0;
                            scl_oe          <= 1'b0;
                            state_reg       <= I2CSAD_TX;
                        end
                    end
                    I2CSAD_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == BITS_PER_BYTE - 4'h1) begin
                                sda_oe    <= 1'b0;
                                state_reg <= I2CSAD_TX_ACK;
                            end else begin
                                shift_reg   <= {shift_reg[6:0], 1'b0};
                                sda_oe      <= !shift_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    I2CSAD_TX_ACK: begin
                        if (scl_rise) begin
                            tx_acked_reg <= !sda_s;
                        end else if (scl_fall) begin
                            scl_oe    <= tx_acked_reg;
                            state_reg <= tx_acked_reg ? I2CSAD_TX_WAIT :
                                                        I2CSAD_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= I2CSAD_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // i2csad_core
`default_nettype wire

// ---- dv/i2csad_core_sva.sv ----
// Checker: APB timing, read field widths, command stream holding.
// Sees only the core's ports; bound to every core below.
`timescale 1ns/1ps
`default_nettype none
module i2csad_core_sva
    import i2csad_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Command stream and interrupt
    input wire logic        mst_cmd_valid,
    input wire logic        mst_cmd_read,
    input wire logic [7:0]  mst_cmd_data,
    input wire logic        mst_cmd_ready,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd_own = pready && !pwrite && paddr == ADDR_OWN;
    wire logic rd_dat = pready && !pwrite && paddr == ADDR_DATA;
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("pready outside access");
    property p_err;
        pslverr |-> pready && paddr != ADDR_OWN && paddr != ADDR_DATA;
    endproperty
    a_err: assert property (p_err) else $error("pslverr on mapped");
    property p_own; rd_own |-> prdata[31:10] == 22'h0; endproperty
    a_own: assert property (p_own) else $error("own read wide");
    property p_dat; rd_dat |-> prdata[31:8] == 24'h0; endproperty
    a_dat: assert property (p_dat) else $error("data read wide");
    property p_rdz; mst_cmd_valid && mst_cmd_read |-> !mst_cmd_data; endproperty
    a_rdz: assert property (p_rdz) else $error("read carries data");
    property p_hold;
        mst_cmd_valid && !mst_cmd_ready |=> mst_cmd_valid &&
            $stable(mst_cmd_read) && $stable(mst_cmd_data);
    endproperty
    a_hold: assert property (p_hold) else $error("command dropped");
    c_take: cover property (mst_cmd_valid && mst_cmd_ready);
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
endmodule // i2csad_core_sva
bind i2csad_core i2csad_core_sva u_sva (.pclk, .presetn, .psel, .penable,
    .pwrite, .pready, .pslverr, .mst_cmd_valid, .mst_cmd_read,
    .mst_cmd_ready, .irq, .paddr, .prdata, .mst_cmd_data);
`default_nettype wire

// ---- dv/i2csad_remote.sv ----
// Remote two-wire bus master at 200 ns per bit.
// Lines have pull-ups; a pull output high drives its line low.
`timescale 1ns/1ps
`default_nettype none
module i2csad_remote (
    // Bus lines and drives
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_pull = 1'b0,
    output logic      sda_pull = 1'b0
);
    // One bit; waits out clock stretching by the device
    task automatic bit_io(input logic b, output logic s);
        sda_pull = !b;
        #50;
        scl_pull = 1'b0;
        wait (scl_line === 1'b1);
        #50;
        s = sda_line;
        #50;
        scl_pull = 1'b1;
        #50;
    endtask
    // MSB first; tx of all ones reads a byte
    task automatic xfer(input logic [7:0] tx, input logic ai,
                        output logic [7:0] rx, output logic ao);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(ai, ao);
    endtask
    task automatic start();
        sda_pull = 1'b1;
        #100;
        scl_pull = 1'b1;
        // Hold so the first data bit never moves with the clock fall
        #50;
    endtask
    task automatic stop();
        sda_pull = 1'b1;
        #50;
        scl_pull = 1'b0;
        wait (scl_line === 1'b1);
        #100;
        sda_pull = 1'b0;
        #100;
    endtask
endmodule // i2csad_remote
`default_nettype wire

// ---- dv/i2csad_core_tb_top.sv ----
// Bench: APB tasks drive the core, a remote model works the bus.
// Checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
module i2csad_core_tb_top;
    import i2csad_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        scl_out, scl_oe, sda_out, sda_oe, scl_pull, sda_pull, ack;
    logic        mst_cmd_valid, mst_cmd_read, mst_cmd_ready, err;
    logic [31:0] paddr, pwdata, prdata;
    logic [7:0]  mst_cmd_data, rx;
    int          n_fail, n_tests;
    wire logic   scl = !(scl_oe || scl_pull);
    wire logic   sda = !(sda_oe || sda_pull);
    i2csad_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .scl_out,
        .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .mst_cmd_valid,
        .mst_cmd_read, .mst_cmd_data, .mst_cmd_ready, .irq);
    i2csad_remote rem (.scl_line(scl), .sda_line(sda), .scl_pull, .sda_pull);
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end
    task automatic chk(input string s, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        if (!w) chk($sformatf("reg %h", a), prdata, d);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic take(input logic r, input logic [7:0] d);
        for (int i = 0; i < 20 && mst_cmd_valid !== 1'b1; i++) @(posedge pclk);
        chk("command", {mst_cmd_valid, mst_cmd_read, mst_cmd_data}, {1'b1, r, d});
        mst_cmd_ready <= 1'b1;
        @(posedge pclk);
        mst_cmd_ready <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, mst_cmd_ready, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_OWN, 32'h55);
        apb(1'b1, ADDR_OWN, 32'hFFFF_FAD5);
        apb(1'b0, ADDR_OWN, 32'h2D5);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_OWN, 32'h111);
        apb(1'b0, ADDR_OWN, 32'h2D5);
        apb(1'b1, 32'h5000_1300, 32'h0);
        chk("pslverr", err, 1'b1);
        rem.start();
        rem.xfer(8'hAA, 1'b1, rx, ack);
        rem.xfer(8'h3C, 1'b1, rx, ack);
        rem.xfer(8'hC3, 1'b1, rx, ack);
        rem.stop();
        apb(1'b0, ADDR_DATA, 32'h3C);
        apb(1'b0, ADDR_DATA, 32'hC3);
        apb(1'b0, ADDR_RAWSTAT, 32'h204);
        apb(1'b1, ADDR_RAWSTAT, 32'h3FF);
        apb(1'b1, ADDR_MASK, 32'h40);
        rem.start();
        rem.xfer(8'hAB, 1'b1, rx, ack);
        apb(1'b0, ADDR_RAWSTAT, 32'h20);
        chk("irq", irq, 1'b0);
        apb(1'b1, ADDR_DATA, 32'h1FF);
        apb(1'b0, ADDR_RAWSTAT, 32'h60);
        chk("irq", irq, 1'b1);
        fork
            rem.xfer(8'hFF, 1'b1, rx, ack);
            apb(1'b1, ADDR_DATA, 32'h0A5);
        join
        chk("slave byte", rx, 8'hA5);
        rem.stop();
        apb(1'b1, ADDR_RAWSTAT, 32'h3FF);
        @(posedge pclk);
        chk("irq", irq, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_DATA, 32'h1A5);
        take(1'b1, 8'h00);
        apb(1'b1, ADDR_DATA, 32'h05A);
        take(1'b0, 8'h5A);
        apb(1'b1, ADDR_CTRL, 32'h803);
        apb(1'b1, ADDR_DATA, 32'h100);
        apb(1'b0, ADDR_RAWSTAT, 32'h40);
        chk("gc valid", mst_cmd_valid, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h9);
        rem.start();
        rem.xfer(8'hF4, 1'b1, rx, ack);
        rem.xfer(8'hD5, 1'b1, rx, ack);
        chk("ten-bit ack", ack, 1'b0);
        rem.xfer(8'h77, 1'b1, rx, ack);
        rem.stop();
        apb(1'b0, ADDR_DATA, 32'h77);
        chk("pins", {scl_out, sda_out}, 2'b00);
        wrap_up();
    end
endmodule // i2csad_core_tb_top
`default_nettype wire
